// *** logic/prec_pkg.sv ***
// Shared constants and types for the card-response emulator
package prec_pkg;

    // Clock and carrier figures
    localparam logic [63:0] CLK_HZ = 64'd10000000;
    localparam logic [63:0] CARRIER_FREQUENCY_HZ = 64'd13560000;
    localparam logic [63:0] SUBCARRIER_DIV = 64'd16;
    localparam logic [63:0] NCO_SCALE = 64'h0000000100000000;
    // Phase step per clock for carrier_frequency/16; truncation error is far below 1 ppm
    localparam logic [63:0] NCO_INC_FULL =
        (CARRIER_FREQUENCY_HZ * NCO_SCALE) / (SUBCARRIER_DIV * CLK_HZ);
    localparam logic [31:0] NCO_INC = NCO_INC_FULL[31:0];

    // Bit coding: index of the last subcarrier period in a bit (8 per bit) and periods per half bit
    localparam logic [2:0] SUB_LAST_IN_BIT = 3'h7;
    localparam logic [2:0] SUB_HALF_BIT = 3'h4;

    // Quiet time after the last reader pause that closes a command
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned EOS_QUIET_NS = 4000;
    localparam logic [7:0] EOS_QUIET_CYC = 8'((EOS_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Load-modulation amplitude range in millivolts
    localparam logic [12:0] AMP_MIN_MV = 13'h01F4;
    localparam logic [12:0] AMP_MAX_MV = 13'h1388;

    // Frame trail geometry
    localparam int unsigned TRAIL_DEPTH = 8;
    localparam int unsigned TRAIL_AW = 3;
    localparam int unsigned MAX_BITS = 64;
    localparam int unsigned LEN_W = 7;

    typedef enum logic [1:0] {
        PREC_IDLE = 2'b00,
        PREC_DELAY = 2'b01,
        PREC_SEND = 2'b10
    } prec_state_e;

endpackage : prec_pkg

// *** logic/prec_coder_if.sv ***
// Link between the sequencer and the coding generator
`timescale 1ns/1ns
interface prec_coder_if;
    logic start;
    logic [prec_pkg::MAX_BITS-1:0] bits;
    logic [prec_pkg::LEN_W-1:0] bitCount;
    logic busy;
    logic done;
    logic loadOn;

    modport seq (output start, output bits, output bitCount,
                 input busy, input done, input loadOn);
    modport coder (input start, input bits, input bitCount,
                   output busy, output done, output loadOn);
endinterface : prec_coder_if

// *** logic/prec_coder.sv ***
// Coding generator: subcarrier NCO and bit-level load coding
`timescale 1ns/1ns
module prec_coder (
    input wire logic clk,
    input wire logic rst,
    prec_coder_if.coder cif
);
    typedef struct packed {
        logic busy;
        logic done;
        logic loadOn;
        logic [31:0] nco;
        logic [2:0] subCnt;
        logic [prec_pkg::LEN_W-1:0] bitIdx;
        logic [prec_pkg::LEN_W-1:0] lastBit;
        logic [prec_pkg::MAX_BITS-1:0] shift;
    } prec_coder_s;

    localparam prec_coder_s CODER_RESET = '0;

    prec_coder_s st;
    prec_coder_s next_st;
    logic [32:0] sum;
    logic wrap;

    // Next state: NCO advances, bits leave LSB first
    always_comb begin
        next_st = st;
        sum = {1'b0, st.nco} + {1'b0, prec_pkg::NCO_INC};
        wrap = sum[32];
        next_st.done = 1'b0;
        next_st.nco = sum[31:0];
        if (cif.start) begin
            // Phase restarts at the answer start, so timing is exact to the clock
            next_st.nco = '0;
            next_st.subCnt = '0;
            next_st.bitIdx = '0;
            next_st.shift = cif.bits;
            next_st.lastBit = cif.bitCount - 7'h01;
            next_st.busy = (cif.bitCount != '0);
            next_st.done = (cif.bitCount == '0);
        end else if (st.busy && wrap) begin
            next_st.subCnt = st.subCnt + 3'h1;
            if (st.subCnt == prec_pkg::SUB_LAST_IN_BIT) begin
                next_st.shift = st.shift >> 1;
                next_st.bitIdx = st.bitIdx + 7'h01;
                if (st.bitIdx == st.lastBit) begin
                    next_st.busy = 1'b0;
                    next_st.done = 1'b1;
                end
            end
        end
        // One level is load present, the other load absent
        next_st.loadOn = next_st.busy && next_st.nco[31] &&
            ((next_st.subCnt < prec_pkg::SUB_HALF_BIT) ? next_st.shift[0]
                                                      : !next_st.shift[0]);
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= CODER_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cif.busy = st.busy;
    assign cif.done = st.done;
    assign cif.loadOn = st.loadOn;
endmodule : prec_coder

// *** logic/prec_response_emulator.sv ***
// Top of the card-response emulator: command end detection, delay, frame trail
// Functional notes
// - One output line carries the coded answer, high for load present, low for absent.
// - Output transitions are placed on a fixed clock grid as fine as the clock allows.
// - The subcarrier is the carrier divided by sixteen with under 10 ppm error.
// - Every reader command is detected and a marker pulse flags its end of sequence.
// - The marker comes early enough for the answer to start inside its timing window.
// - After the marker the answer waits for a programmed delay of fine steps.
// - The answer start is accurate to within one clock period (100 ns) from the command.
// - A separate trigger pulse goes to the acquisition equipment.
// - Answer bits and length come from a stored frame trail, one step per answered command.
// - The amplitude setting is held within 0.5 V to 5 V.
// - Timing is derived from a nominal carrier of 13.56 MHz.
`timescale 1ns/1ns
module prec_response_emulator (
    input wire logic clk,
    input wire logic rst,
    input wire logic readerPause,
    input wire logic [15:0] responseDelay,
    input wire logic trailWrite,
    input wire logic [prec_pkg::TRAIL_AW-1:0] trailAddr,
    input wire logic [prec_pkg::MAX_BITS-1:0] trailData,
    input wire logic [prec_pkg::LEN_W-1:0] trailLen,
    input wire logic trailRestart,
    input wire logic [12:0] amplitudeSetting,
    output logic loadModulation,
    output logic commandEndMarker,
    output logic acqTrigger,
    output logic responseActive,
    output logic [prec_pkg::TRAIL_AW-1:0] trailStep,
    output logic [12:0] amplitudeMv
);
    typedef struct packed {
        logic pauseMeta;
        logic pauseSync;
        logic pauseSeen;
        logic [7:0] quietCnt;
        logic marker;
        prec_pkg::prec_state_e state;
        logic [15:0] delayCnt;
        logic start;
        logic acq;
        logic active;
        logic load;
        logic [prec_pkg::TRAIL_AW-1:0] step;
        logic [prec_pkg::MAX_BITS-1:0] bits;
        logic [prec_pkg::LEN_W-1:0] bitCount;
        logic [12:0] amp;
    } prec_top_s;

    localparam prec_top_s TOP_RESET = '{
        state: prec_pkg::PREC_IDLE,
        amp: prec_pkg::AMP_MIN_MV,
        default: '0
    };

    prec_top_s st;
    prec_top_s next_st;

    // Frame trail storage: answer bits and bit count per step
    logic [prec_pkg::MAX_BITS-1:0] trailBits [prec_pkg::TRAIL_DEPTH];
    logic [prec_pkg::LEN_W-1:0] trailBitCount [prec_pkg::TRAIL_DEPTH];

    prec_coder_if cif ();

    prec_coder u_coder (
        .clk(clk),
        .rst(rst),
        .cif(cif)
    );

    assign cif.start = st.start;
    assign cif.bits = st.bits;
    assign cif.bitCount = st.bitCount;

    // Trail is loaded by the bench controller before the test
    always_ff @(posedge clk) begin
        if (trailWrite) begin
            trailBits[trailAddr] <= trailData;
            trailBitCount[trailAddr] <= trailLen;
        end
    end

    // Next state of the whole sequencer
    always_comb begin
        next_st = st;
        next_st.pauseMeta = readerPause;
        next_st.pauseSync = st.pauseMeta;
        next_st.marker = 1'b0;
        next_st.start = 1'b0;
        next_st.acq = 1'b0;
        next_st.load = cif.loadOn;

        // End of sequence: a quiet stretch after the last pause closes the command
        if (st.pauseSync) begin
            next_st.pauseSeen = 1'b1;
            next_st.quietCnt = '0;
        end else if (st.pauseSeen) begin
            if (st.quietCnt == prec_pkg::EOS_QUIET_CYC - 8'h01) begin
                next_st.marker = 1'b1;
                next_st.pauseSeen = 1'b0;
                next_st.quietCnt = '0;
            end else begin
                next_st.quietCnt = st.quietCnt + 8'h01;
            end
        end

        // Commands heard while answering are not answered
        unique case (st.state)
            prec_pkg::PREC_IDLE: begin
                if (st.marker) begin
                    next_st.delayCnt = responseDelay;
                    next_st.state = prec_pkg::PREC_DELAY;
                end
            end
            prec_pkg::PREC_DELAY: begin
                if (st.delayCnt == '0) begin
                    next_st.start = 1'b1;
                    next_st.acq = 1'b1;
                    next_st.active = 1'b1;
                    next_st.bits = trailBits[st.step];
                    next_st.bitCount = trailBitCount[st.step];
                    next_st.state = prec_pkg::PREC_SEND;
                end else begin
                    next_st.delayCnt = st.delayCnt - 16'h0001;
                end
            end
            prec_pkg::PREC_SEND: begin
                if (cif.done) begin
                    next_st.active = 1'b0;
                    next_st.step = st.step + 3'h1;
                    next_st.state = prec_pkg::PREC_IDLE;
                end
            end
            default: begin
                next_st.state = prec_pkg::PREC_IDLE;
            end
        endcase

        // Restart wins over a step advance in the same cycle
        if (trailRestart) begin
            next_st.step = '0;
        end

        // Amplitude clamped to the analogue stage range
        if (amplitudeSetting < prec_pkg::AMP_MIN_MV) begin
            next_st.amp = prec_pkg::AMP_MIN_MV;
        end else if (amplitudeSetting > prec_pkg::AMP_MAX_MV) begin
            next_st.amp = prec_pkg::AMP_MAX_MV;
        end else begin
            next_st.amp = amplitudeSetting;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= TOP_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign loadModulation = st.load;
    assign commandEndMarker = st.marker;
    assign acqTrigger = st.acq;
    assign responseActive = st.active;
    assign trailStep = st.step;
    assign amplitudeMv = st.amp;
endmodule : prec_response_emulator

// *** test/prec_monitor.sv ***
// Port checker for the card-response emulator
`timescale 1ns/1ns
module prec_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic readerPause,
    input wire logic [15:0] responseDelay,
    input wire logic [12:0] amplitudeSetting,
    input wire logic loadModulation,
    input wire logic commandEndMarker,
    input wire logic acqTrigger,
    input wire logic responseActive,
    input wire logic [12:0] amplitudeMv
);
    logic [5:0] lowCnt;
    logic [15:0] dly;
    logic [15:0] cnt;
    logic armed;
    logic [12:0] ampExp;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Quiet count saturates at 63, so reset alone never looks like a command end
    always_ff @(posedge clk) begin
        ampExp <= amplitudeSetting < 13'h01F4 ? 13'h01F4 :
            (amplitudeSetting > 13'h1388 ? 13'h1388 : amplitudeSetting);
        cnt <= cnt + 16'h0001;
        if (rst || acqTrigger) begin
            armed <= 1'b0;
        end else if (commandEndMarker && !armed && !responseActive) begin
            armed <= 1'b1;
            dly <= responseDelay;
            cnt <= 16'h0000;
        end
        if (rst) lowCnt <= 6'h3F;
        else if (readerPause) lowCnt <= 6'h00;
        else if (lowCnt != 6'h3F) lowCnt <= lowCnt + 6'h01;
    end
    sequence quietRun;
        lowCnt == 6'h1E ##1 !readerPause [*8];
    endsequence
    sequence subHigh;
        loadModulation [*5];
    endsequence
    markerPulse_a: assert property (commandEndMarker |=> !commandEndMarker)
        else $error("end marker too long");
    markerDue_a: assert property (quietRun |-> ##[0:6] commandEndMarker)
        else $error("end marker missing");
    quietMarker_a: assert property (commandEndMarker |-> lowCnt >= 6'h26 && lowCnt <= 6'h2C)
        else $error("end marker at wrong time");
    acqPulse_a: assert property (acqTrigger |=> !acqTrigger)
        else $error("acquisition trigger too long");
    startTime_a: assert property (armed |-> acqTrigger == (cnt == dly + 16'h0001))
        else $error("answer start off delay");
    startCause_a: assert property (acqTrigger |-> armed && $rose(responseActive))
        else $error("answer start without cause");
    loadIdle_a: assert property (!responseActive [*3] |-> !loadModulation)
        else $error("load on while idle");
    subHigh_a: assert property ($rose(loadModulation) |-> subHigh ##[1:2] !loadModulation)
        else $error("subcarrier half period wrong");
    ampClamp_a: assert property (!$past(rst) |-> amplitudeMv == ampExp)
        else $error("amplitude clamp wrong");
endmodule : prec_monitor
bind prec_response_emulator prec_monitor u_mon (.clk, .rst, .readerPause, .responseDelay,
    .amplitudeSetting, .loadModulation, .commandEndMarker, .acqTrigger, .responseActive,
    .amplitudeMv);

// *** test/prec_reader_model.sv ***
// Behavioural reader that sends pause-coded commands
`timescale 1ns/1ns
module prec_reader_model (
    input wire logic clk,
    output logic readerPause
);
    initial readerPause = 1'b0;
    // A command is a train of short pauses; the line then rests low
    task automatic sendCommand(input int pauses);
        repeat (pauses) begin
            @(posedge clk) readerPause <= 1'b1;
            repeat (3) @(posedge clk);
            readerPause <= 1'b0;
            repeat (9) @(posedge clk);
        end
    endtask : sendCommand
endmodule : prec_reader_model

// *** test/prec_tb.sv ***
// Self-checking testbench for the card-response emulator
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic readerPause, trailWrite, trailRestart;
    logic [15:0] responseDelay;
    logic [2:0] trailAddr, trailStep;
    logic [63:0] trailData, got;
    logic [6:0] trailLen;
    logic [12:0] amplitudeSetting, amplitudeMv;
    logic loadModulation, commandEndMarker, acqTrigger, responseActive;
    int n_fail = 0;
    int check_count = 0;
    int cyc;
    // Clock of 100 ns
    always #50 clk = ~clk;
    prec_reader_model rdr (.clk, .readerPause);
    prec_response_emulator DUT (.clk, .rst, .readerPause, .responseDelay, .trailWrite,
        .trailAddr, .trailData, .trailLen, .trailRestart, .amplitudeSetting, .loadModulation,
        .commandEndMarker, .acqTrigger, .responseActive, .trailStep, .amplitudeMv);
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic waitFor(ref logic sig, input int lim);
        cyc = 0;
        do begin
            @(posedge clk);
            cyc++;
        end while (sig !== 1'b1 && cyc < lim);
        if (sig !== 1'b1) begin
            check(0, 1);
            end_sim();
        end
    endtask : waitFor
    // Stores one answer at the current step and sends a command
    task automatic t_answer(input logic [15:0] d, input logic [63:0] data,
        input logic [6:0] len);
        logic q[$];
        int h[2];
        logic [2:0] s0;
        s0 = trailStep;
        @(posedge clk);
        trailWrite <= 1'b1;
        trailAddr <= s0;
        trailData <= data;
        trailLen <= len;
        responseDelay <= d;
        @(posedge clk);
        trailWrite <= 1'b0;
        rdr.sendCommand(3);
        waitFor(commandEndMarker, 200);
        waitFor(acqTrigger, d + 9);
        check(cyc, d + 2);
        do begin
            @(posedge clk);
            q.push_back(loadModulation);
        end while (responseActive === 1'b1 && q.size() < 7000);
        check(responseActive, 1'b0);
        got = '0;
        cyc = 0;
        for (int j = 1; j < q.size(); j++) cyc += (q[j] && !q[j-1]);
        // A bit is 94.4 cycles; the busier half decides its value
        for (int i = 0; i < len; i++) begin
            h = '{0, 0};
            for (int j = 1 + i * 944 / 10; j < 1 + (i * 944 + 944) / 10 && j < q.size(); j++)
                h[j >= 1 + (i * 944 + 472) / 10] += q[j];
            got[i] = h[0] > h[1];
        end
        check(got, data);
        check(cyc, len * 4);
        repeat (2) @(posedge clk);
        check(trailStep, s0 + 3'h1);
        $display("answer test done");
    endtask : t_answer
    // A command during an answer must not start another one
    task automatic t_busy();
        logic [2:0] s0;
        s0 = trailStep;
        @(posedge clk);
        trailWrite <= 1'b1;
        trailAddr <= s0;
        trailLen <= 7'h08;
        @(posedge clk);
        trailWrite <= 1'b0;
        rdr.sendCommand(2);
        waitFor(acqTrigger, 300);
        rdr.sendCommand(2);
        waitFor(commandEndMarker, 200);
        got = '0;
        repeat (900) begin
            @(posedge clk);
            got[0] = got[0] | acqTrigger;
        end
        check(got, 0);
        check(trailStep, s0 + 3'h1);
        @(posedge clk) trailRestart <= 1'b1;
        @(posedge clk) trailRestart <= 1'b0;
        repeat (2) @(posedge clk);
        check(trailStep, 0);
        $display("busy test done");
    endtask : t_busy
    task automatic t_amp();
        logic [12:0] v[5] = '{13'h0000, 13'h01F3, 13'h0BB8, 13'h1388, 13'h1FFF};
        logic [12:0] e[5] = '{13'h01F4, 13'h01F4, 13'h0BB8, 13'h1388, 13'h1388};
        foreach (v[i]) begin
            @(posedge clk) amplitudeSetting <= v[i];
            repeat (2) @(posedge clk);
            check(amplitudeMv, e[i]);
        end
        $display("amplitude test done");
    endtask : t_amp
    initial begin
        {trailWrite, trailRestart, responseDelay, trailAddr, trailData, trailLen} = '0;
        amplitudeSetting = 13'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check(amplitudeMv, 13'h01F4);
        check({loadModulation, responseActive, trailStep}, 0);
        t_amp();
        t_answer(16'h0000, 64'hA, 7'h04);
        t_answer(16'h0001, 64'h0, 7'h00);
        t_answer(16'h0025, 64'h35, 7'h06);
        t_busy();
        end_sim();
    end
endmodule : testbench
